// ==== afe_sched_pkg.sv ====
// Purpose: shared constants for the front-end poll scheduler block
// Assumes: 100 MHz clock, 4000 Hz scheduler tick
// Notes:   register offsets are byte addresses on a 32-bit bus
package afe_sched_pkg;

  localparam int CLK_HZ      = 100_000_000;
  localparam int TICK_HZ     = 4000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;

  localparam int DELAY_A_MS    = 0;
  localparam int DELAY_B_MS    = 20;
  localparam int DELAY_C_MS    = 40;
  localparam int DELAY_A_TICKS = DELAY_A_MS * TICK_HZ / 1000;
  localparam int DELAY_B_TICKS = DELAY_B_MS * TICK_HZ / 1000;
  localparam int DELAY_C_TICKS = DELAY_C_MS * TICK_HZ / 1000;

  localparam int RD_TIMEOUT_MS     = 1050;
  localparam int CMD_TIMEOUT_MS    = 250;
  localparam int RD_TIMEOUT_TICKS  = RD_TIMEOUT_MS * TICK_HZ / 1000;
  localparam int CMD_TIMEOUT_TICKS = CMD_TIMEOUT_MS * TICK_HZ / 1000;

  // energy: 1 kWh in 0.001 W x tick units
  localparam logic [51:0] KWH_THRESHOLD = 52'h0_0D18_C2E2_8000;
  localparam logic [15:0] PPK_RESET     = 16'h1900;
  localparam logic [15:0] PWIDTH_RESET  = 16'h0028;
  localparam logic [31:0] CUTOFF_RESET  = 32'h0000_0000;

  localparam logic [7:0] CMD_READ_BASE = 8'h60;
  localparam logic [7:0] CMD_CAL_BASE  = 8'h70;
  localparam logic [7:0] CMD_SYNC      = 8'h5A;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CUTOFF = 8'h08;
  localparam logic [7:0] OFS_PPK    = 8'h0C;
  localparam logic [7:0] OFS_PWIDTH = 8'h10;
  localparam logic [7:0] OFS_ACT    = 8'h20;
  localparam logic [7:0] OFS_REACT  = 8'h30;
  localparam logic [7:0] OFS_STAMP  = 8'h40;

  // control field positions
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_TWO_BIT   = 1;
  localparam int CTRL_SYNC_BIT  = 2;
  localparam int CTRL_CAL_LSB   = 4;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} sched_state_t;
  typedef enum logic [1:0] {K_SYNC, K_CAL, K_READ} cmd_kind_t;

endpackage : afe_sched_pkg

// ==== afe_poll_scheduler.sv ====
// Purpose: polls three metrology front ends and makes energy pulses
// Assumes: front-end pins asynchronous; uart tx/rx cores on clk_i
// Notes:   registers on ahb-lite, zero wait states
//
// Functional notes
// - record assertion order for phase sequence
// - store tick count at each assertion
// - request delay 0/20/40 ms per phase
// - scheduler and energy run on 4000 Hz tick
// - pending sync sent to all from tick
// - pending calibration request sent from tick
// - per-phase readings timeout about 1.05 s
// - readings timeout zeroes params, flags phase missing
// - command timeout 0.25 s after sending
// - only one request outstanding at a time
// - receive routed only from addressed front end
// - two-channel pin serial while request open
// - add power only above residual cutoff
// - phase below cutoff adds nothing to aggregate
// - pulse on threshold cross, keep excess
// - default 6400 pulses per kWh
// - power in mW, kWh threshold D18C2E28000
// - same average power added every tick
// - pulses per kWh and width configurable
// - read command byte is 0x60 plus phase
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ns
module afe_poll_scheduler
  import afe_sched_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // front-end pins, one per phase; uart_rx_o is the single line to the uart receiver
  input  wire logic [2:0]  new_params_line_n_i,
  input  wire logic [2:0]  rx_pin_i,
  output logic      [2:0]  rx_sel_o,
  output logic      [2:0]  pin_uart_mode_o,
  output logic             uart_rx_o,
  // command byte to uart transmitter
  output logic             cmd_valid_o,
  output logic      [7:0]  cmd_byte_o,
  input  wire logic        cmd_ready_i,
  // response done from packet checker
  input  wire logic        resp_done_i,
  // status and pulses
  output logic      [2:0]  phase_missing_o,
  output logic             act_pulse_o,
  output logic             react_pulse_o
);

  logic [31:0]  tick_div_reg;
  logic         tick;
  logic [15:0]  tick_cnt_reg;
  logic [2:0]   nd_s1_reg, nd_s2_reg, nd_s3_reg;
  logic [2:0]   rx_s1_reg, rx_s2_reg;
  logic [2:0]   nd_fall;
  logic [5:0]   seq_reg;
  logic [15:0]  stamp_reg [3];
  logic [2:0]   pend_reg;
  logic [2:0]   due;
  logic [2:0]   rd_issue;
  logic [2:0]   rd_ok;
  logic [2:0]   rd_to;
  logic [12:0]  rd_age_reg [3];
  logic [2:0]   missing_reg;
  sched_state_t state_reg;
  cmd_kind_t    kind_reg;
  logic [1:0]   cur_ph_reg;
  logic [9:0]   cmd_age_reg;
  logic         en_reg, two_ch_reg;
  logic         sync_pend_reg, cal_pend_reg;
  logic [1:0]   cal_ph_reg;
  logic         sync_wr, cal_wr, sync_sent, cal_sent;
  logic [31:0]  cutoff_reg;
  logic [15:0]  ppk_reg, pwidth_reg;
  logic [31:0]  act_pwr_reg [3];
  logic [31:0]  react_pwr_reg [3];
  logic [51:0]  act_acc_reg, react_acc_reg;
  logic [51:0]  act_acc_next, react_acc_next;
  logic         act_fire, react_fire;
  logic [15:0]  act_w_reg, react_w_reg;
  logic         wr_pend_reg;
  logic [7:0]   wr_addr_reg;
  logic         rd_req, wr_req;
  logic [31:0]  rd_mux;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tick_div_reg <= 32'h0000_0000;
      tick_cnt_reg <= 16'h0000;
    end else if (ce_i) begin
      if (tick) begin
        tick_div_reg <= 32'h0000_0000;
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end else begin
        tick_div_reg <= tick_div_reg + 32'h0000_0001;
      end
    end
  end
  assign tick = (tick_div_reg == 32'(TICK_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      nd_s1_reg <= 3'h7;
      nd_s2_reg <= 3'h7;
      nd_s3_reg <= 3'h7;
      rx_s1_reg <= 3'h7;
      rx_s2_reg <= 3'h7;
    end else if (ce_i) begin
      nd_s1_reg <= new_params_line_n_i;
      nd_s2_reg <= nd_s1_reg;
      nd_s3_reg <= nd_s2_reg;
      rx_s1_reg <= rx_pin_i;
      rx_s2_reg <= rx_s1_reg;
    end
  end
  // no edges while the shared pin carries serial data
  assign nd_fall = nd_s3_reg & ~nd_s2_reg & ~pin_uart_mode_o;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      seq_reg <= 6'h00;
    end else if (ce_i) begin
      for (int p = 0; p < 3; p++)
        if (nd_fall[p]) seq_reg <= {seq_reg[3:0], 2'(p + 1)};
    end
  end

  function automatic logic [15:0] delay_of(input int p);
    delay_of = (p == 0) ? 16'(DELAY_A_TICKS) :
               (p == 1) ? 16'(DELAY_B_TICKS) : 16'(DELAY_C_TICKS);
  endfunction : delay_of

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_phase
      assign due[g] = pend_reg[g] &&
        ((tick_cnt_reg - stamp_reg[g]) >= delay_of(g));
      assign rd_ok[g] = (state_reg == ST_WAIT) && (kind_reg == K_READ) &&
                        (cur_ph_reg == 2'(g)) && resp_done_i;
      assign rd_to[g] = tick && !rd_ok[g] &&
                        (rd_age_reg[g] == 13'(RD_TIMEOUT_TICKS - 1));

      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          stamp_reg[g] <= 16'h0000;
          pend_reg[g]  <= 1'b0;
        end else if (ce_i) begin
          if (nd_fall[g]) begin
            stamp_reg[g] <= tick_cnt_reg;
            pend_reg[g]  <= 1'b1;
          end else if (rd_issue[g]) begin
            pend_reg[g]  <= 1'b0;
          end
        end
      end

      // age runs whether or not the line ever asserted
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          rd_age_reg[g]  <= 13'h0000;
          missing_reg[g] <= 1'b0;
        end else if (ce_i) begin
          if (rd_ok[g]) begin
            rd_age_reg[g]  <= 13'h0000;
            missing_reg[g] <= 1'b0;
          end else if (rd_to[g]) begin
            rd_age_reg[g]  <= 13'h0000;
            missing_reg[g] <= 1'b1;
          end else if (tick) begin
            rd_age_reg[g]  <= rd_age_reg[g] + 13'h0001;
          end
        end
      end
    end
  endgenerate
  assign phase_missing_o = missing_reg;

  // priority: sync, calibration, then readings A..C
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg       <= ST_IDLE;
      kind_reg        <= K_SYNC;
      cur_ph_reg      <= 2'h0;
      cmd_age_reg     <= 10'h000;
      cmd_valid_o     <= 1'b0;
      cmd_byte_o      <= 8'h00;
      rx_sel_o        <= 3'h0;
      pin_uart_mode_o <= 3'h0;
    end else if (ce_i) begin
      case (state_reg)
        ST_IDLE: begin
          if (tick && en_reg) begin
            if (sync_pend_reg) begin
              kind_reg    <= K_SYNC;
              cmd_byte_o  <= CMD_SYNC;
              cmd_valid_o <= 1'b1;
              state_reg   <= ST_SEND;
            end else if (cal_pend_reg) begin
              kind_reg        <= K_CAL;
              cur_ph_reg      <= cal_ph_reg;
              cmd_byte_o      <= CMD_CAL_BASE + 8'(cal_ph_reg);
              cmd_valid_o     <= 1'b1;
              rx_sel_o        <= 3'(1 << (cal_ph_reg - 2'h1));
              pin_uart_mode_o <= two_ch_reg ?
                                 3'(1 << (cal_ph_reg - 2'h1)) : 3'h0;
              state_reg       <= ST_SEND;
            end else begin
              for (int p = 2; p >= 0; p--) begin
                if (due[p]) begin
                  kind_reg        <= K_READ;
                  cur_ph_reg      <= 2'(p);
                  cmd_byte_o      <= CMD_READ_BASE + 8'(p + 1);
                  cmd_valid_o     <= 1'b1;
                  rx_sel_o        <= 3'(1 << p);
                  pin_uart_mode_o <= two_ch_reg ? 3'(1 << p) : 3'h0;
                  state_reg       <= ST_SEND;
                end
              end
            end
          end
        end
        ST_SEND: begin
          if (cmd_ready_i) begin
            cmd_valid_o <= 1'b0;
            cmd_age_reg <= 10'h000;
            state_reg   <= (kind_reg == K_SYNC) ? ST_IDLE : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (resp_done_i ||
              (tick && cmd_age_reg == 10'(CMD_TIMEOUT_TICKS - 1))) begin
            state_reg       <= ST_IDLE;
            rx_sel_o        <= 3'h0;
            pin_uart_mode_o <= 3'h0;
          end else if (tick) begin
            cmd_age_reg <= cmd_age_reg + 10'h001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_comb begin
    rd_issue = 3'h0;
    if (state_reg == ST_SEND && cmd_ready_i && kind_reg == K_READ) begin
      rd_issue[cur_ph_reg] = 1'b1;
    end
  end
  assign sync_sent = (state_reg == ST_SEND) && cmd_ready_i &&
                     (kind_reg == K_SYNC);
  assign cal_sent  = (state_reg == ST_SEND) && cmd_ready_i &&
                     (kind_reg == K_CAL);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      uart_rx_o <= 1'b1;
    end else if (ce_i) begin
      uart_rx_o <= 1'b1;
      for (int p = 0; p < 3; p++)
        if (rx_sel_o[p])
          uart_rx_o <= two_ch_reg ? nd_s2_reg[p] : rx_s2_reg[p];
    end
  end

  // pending requests; a new request beats the clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync_pend_reg <= 1'b0;
      cal_pend_reg  <= 1'b0;
      cal_ph_reg    <= 2'h0;
    end else if (ce_i) begin
      if (sync_wr) sync_pend_reg <= 1'b1;
      else if (sync_sent) sync_pend_reg <= 1'b0;
      if (cal_wr) begin
        cal_pend_reg <= 1'b1;
        cal_ph_reg   <= hwdata_i[CTRL_CAL_LSB +: 2];
      end else if (cal_sent) begin
        cal_pend_reg <= 1'b0;
      end
    end
  end

  function automatic logic [51:0] tick_energy(input logic [31:0] pw [3],
                                              input logic [31:0] cut,
                                              input logic [15:0] ppk);
    logic signed [33:0] sum;
    logic signed [33:0] v;
    logic [33:0]        mag;
    sum = 34'sd0;
    for (int p = 0; p < 3; p++) begin
      v = {{2{pw[p][31]}}, pw[p]};
      mag = v[33] ? 34'(-v) : 34'(v);
      if (mag > {2'b00, cut}) begin
        sum = sum + v;
      end
    end
    mag = sum[33] ? 34'(-sum) : 34'(sum);
    // scaling by pulses-per-kWh avoids dividing the threshold
    tick_energy = 52'(mag * ppk);
  endfunction : tick_energy

  always_comb begin
    act_acc_next   = act_acc_reg +
                     tick_energy(act_pwr_reg, cutoff_reg, ppk_reg);
    react_acc_next = react_acc_reg +
                     tick_energy(react_pwr_reg, cutoff_reg, ppk_reg);
    act_fire   = act_acc_next >= KWH_THRESHOLD;
    react_fire = react_acc_next >= KWH_THRESHOLD;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      act_acc_reg   <= 52'h0_0000_0000_0000;
      react_acc_reg <= 52'h0_0000_0000_0000;
    end else if (ce_i && tick) begin
      act_acc_reg   <= act_fire ? act_acc_next - KWH_THRESHOLD
                                : act_acc_next;
      react_acc_reg <= react_fire ? react_acc_next - KWH_THRESHOLD
                                  : react_acc_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      act_w_reg     <= 16'h0000;
      react_w_reg   <= 16'h0000;
      act_pulse_o   <= 1'b0;
      react_pulse_o <= 1'b0;
    end else if (ce_i && tick) begin
      if (act_fire) begin
        act_w_reg   <= pwidth_reg;
        act_pulse_o <= (pwidth_reg != 16'h0000);
      end else if (act_w_reg > 16'h0001) begin
        act_w_reg   <= act_w_reg - 16'h0001;
      end else begin
        act_w_reg   <= 16'h0000;
        act_pulse_o <= 1'b0;
      end
      if (react_fire) begin
        react_w_reg   <= pwidth_reg;
        react_pulse_o <= (pwidth_reg != 16'h0000);
      end else if (react_w_reg > 16'h0001) begin
        react_w_reg   <= react_w_reg - 16'h0001;
      end else begin
        react_w_reg   <= 16'h0000;
        react_pulse_o <= 1'b0;
      end
    end
  end

  assign rd_req = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  assign wr_req = hsel_i && htrans_i[1] && hready_i && hwrite_i;
  assign sync_wr = wr_pend_reg && (wr_addr_reg == OFS_CTRL) &&
                   hwdata_i[CTRL_SYNC_BIT];
  assign cal_wr  = wr_pend_reg && (wr_addr_reg == OFS_CTRL) &&
                   (hwdata_i[CTRL_CAL_LSB +: 2] != 2'h0);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      hrdata_o    <= 32'h0000_0000;
    end else if (ce_i) begin
      wr_pend_reg <= wr_req && (haddr_i[31:8] == 24'h00_0000);
      wr_addr_reg <= haddr_i[7:0];
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (rd_req) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr_i[31:8] == 24'h00_0000) begin
      if (haddr_i[7:0] == OFS_CTRL)
        rd_mux = {30'h0, two_ch_reg, en_reg};
      else if (haddr_i[7:0] == OFS_STATUS)
        rd_mux = {17'h0_0000, pend_reg, seq_reg, cur_ph_reg,
                  (state_reg != ST_IDLE), missing_reg};
      else if (haddr_i[7:0] == OFS_CUTOFF)
        rd_mux = cutoff_reg;
      else if (haddr_i[7:0] == OFS_PPK)
        rd_mux = {16'h0000, ppk_reg};
      else if (haddr_i[7:0] == OFS_PWIDTH)
        rd_mux = {16'h0000, pwidth_reg};
      for (int p = 0; p < 3; p++) begin
        if (haddr_i[7:0] == OFS_ACT + 8'(4 * p))
          rd_mux = act_pwr_reg[p];
        else if (haddr_i[7:0] == OFS_REACT + 8'(4 * p))
          rd_mux = react_pwr_reg[p];
        else if (haddr_i[7:0] == OFS_STAMP + 8'(4 * p))
          rd_mux = {16'h0000, stamp_reg[p]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      {two_ch_reg, en_reg} <= CTRL_RESET;
      cutoff_reg <= CUTOFF_RESET;
      ppk_reg    <= PPK_RESET;
      pwidth_reg <= PWIDTH_RESET;
    end else if (ce_i && wr_pend_reg) begin
      if (wr_addr_reg == OFS_CTRL) begin
        en_reg     <= hwdata_i[CTRL_EN_BIT];
        two_ch_reg <= hwdata_i[CTRL_TWO_BIT];
      end else if (wr_addr_reg == OFS_CUTOFF)
        cutoff_reg <= hwdata_i;
      else if (wr_addr_reg == OFS_PPK)
        ppk_reg <= hwdata_i[15:0];
      else if (wr_addr_reg == OFS_PWIDTH)
        pwidth_reg <= hwdata_i[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int p = 0; p < 3; p++) begin
        act_pwr_reg[p]   <= 32'h0000_0000;
        react_pwr_reg[p] <= 32'h0000_0000;
      end
    end else if (ce_i) begin
      for (int p = 0; p < 3; p++) begin
        if (rd_to[p]) begin
          act_pwr_reg[p]   <= 32'h0000_0000;
          react_pwr_reg[p] <= 32'h0000_0000;
        end else if (wr_pend_reg && wr_addr_reg == OFS_ACT + 8'(4 * p)) begin
          act_pwr_reg[p] <= hwdata_i;
        end else if (wr_pend_reg &&
                     wr_addr_reg == OFS_REACT + 8'(4 * p)) begin
          react_pwr_reg[p] <= hwdata_i;
        end
      end
    end
  end

endmodule : afe_poll_scheduler

// ==== afe_sched_checker.sv ====
// Purpose: port checks for the front-end poll scheduler
// Assumes: one clock, synchronous reset, ce_i held high by the bench
// Notes:   bound into every scheduler instance
`timescale 1ns/1ns
module afe_sched_checker
  import afe_sched_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       ce_i,
  // bus answer
  input wire logic       hreadyout_o,
  input wire logic       hresp_o,
  // command link
  input wire logic       cmd_valid_o,
  input wire logic [7:0] cmd_byte_o,
  input wire logic       cmd_ready_i,
  input wire logic       resp_done_i,
  // pin steering and status
  input wire logic [2:0] rx_sel_o,
  input wire logic [2:0] pin_uart_mode_o,
  input wire logic [2:0] phase_missing_o
);
  // slack covers a slow accept and tick rounding
  localparam int CTO = (CMD_TIMEOUT_TICKS + 2) * TICK_DIV + 8;
  int unsigned open_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i || rx_sel_o == 3'h0) open_reg <= 0;
    else open_reg <= open_reg + 1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  property p_bus; hreadyout_o && !hresp_o; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or okay");

  property p_hold;
    cmd_valid_o && !cmd_ready_i && ce_i |=> cmd_valid_o && $stable(cmd_byte_o);
  endproperty
  a_hold: assert property (p_hold) else $error("command dropped");

  property p_code;
    cmd_valid_o |-> cmd_byte_o inside {8'h5A, [8'h61:8'h63], [8'h71:8'h73]};
  endproperty
  a_code: assert property (p_code) else $error("bad command byte");

  property p_sel;
    cmd_valid_o && cmd_byte_o[7:4] != 4'h5
      |-> rx_sel_o == 3'(3'h1 << (cmd_byte_o[1:0] - 2'h1));
  endproperty
  a_sel: assert property (p_sel) else $error("wrong receive pin");

  property p_hot; rx_sel_o != 3'h0 |-> $onehot(rx_sel_o); endproperty
  a_hot: assert property (p_hot) else $error("receive not one-hot");

  property p_mode;
    pin_uart_mode_o != 3'h0 |-> pin_uart_mode_o == rx_sel_o;
  endproperty
  a_mode: assert property (p_mode) else $error("pin mode mismatch");

  property p_one;
    $rose(cmd_valid_o) && cmd_byte_o[7:4] != 4'h5 |-> $past(rx_sel_o) == 3'h0;
  endproperty
  a_one: assert property (p_one) else $error("second request open");

  property p_free;
    resp_done_i && ce_i && rx_sel_o != 3'h0 && !cmd_valid_o
      |=> rx_sel_o == 3'h0 && pin_uart_mode_o == 3'h0;
  endproperty
  a_free: assert property (p_free) else $error("pin not released");

  property p_found;
    resp_done_i && ce_i && !cmd_valid_o && cmd_byte_o[7:4] == 4'h6
      |=> (phase_missing_o & $past(rx_sel_o)) == 3'h0;
  endproperty
  a_found: assert property (p_found) else $error("missing kept");

  property p_cto; open_reg <= CTO; endproperty
  a_cto: assert property (p_cto) else $error("no command timeout");
endmodule : afe_sched_checker

bind afe_poll_scheduler afe_sched_checker #(.TICK_DIV(TICK_DIV)) i_chk (
  .clk_i, .reset_i, .ce_i, .hreadyout_o, .hresp_o, .cmd_valid_o,
  .cmd_byte_o, .cmd_ready_i, .resp_done_i, .rx_sel_o, .pin_uart_mode_o,
  .phase_missing_o);

// ==== afe_fe_model.sv ====
// Purpose: three front ends facing the poll scheduler
// Assumes: one answer per accepted read or calibration byte
// Notes:   mute_i silences a phase, slow_i stretches each handshake
`timescale 1ns/1ns
module afe_fe_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // bench controls
  input  wire logic [2:0] kick_i,
  input  wire logic [2:0] mute_i,
  input  wire logic       slow_i,
  // scheduler side
  input  wire logic       cmd_valid_i,
  input  wire logic [7:0] cmd_byte_i,
  output logic      [2:0] new_params_n_o,
  output logic      [2:0] rx_pin_o,
  output logic            cmd_ready_o,
  output logic            resp_done_o
);
  logic [1:0] wait_reg;
  logic [5:0] due_reg;

  always_ff @(posedge clk_i) new_params_n_o <= ~kick_i;
  // toggling, so a stale level cannot pass
  always_ff @(posedge clk_i) rx_pin_o <= reset_i ? 3'h7 : ~rx_pin_o;

  always_ff @(posedge clk_i) begin
    cmd_ready_o <= 1'b0;
    resp_done_o <= 1'b0;
    if (reset_i) begin
      wait_reg <= 2'h0;
      due_reg  <= 6'h00;
    end else begin
      if (cmd_valid_i && !cmd_ready_o) begin
        wait_reg <= wait_reg + 2'h1;
        if (!slow_i || wait_reg == 2'h3) cmd_ready_o <= 1'b1;
      end
      if (cmd_valid_i && cmd_ready_o && cmd_byte_i[7:4] != 4'h5 &&
          !mute_i[cmd_byte_i[1:0] - 2'h1]) begin
        due_reg <= slow_i ? 6'h28 : 6'h05;
      end else if (due_reg != 6'h00) begin
        due_reg     <= due_reg - 6'h01;
        resp_done_o <= (due_reg == 6'h01);
      end
    end
  end
endmodule : afe_fe_model

// ==== tb.sv ====
// Purpose: self-checking bench for the poll scheduler
// Assumes: tick shortened to 10 clocks
// Notes:   front ends come from afe_fe_model
`timescale 1ns/1ns
module tb;
  import afe_sched_pkg::*;
  localparam int TD = 10;
  localparam int TK = TD * 10;
  localparam logic [31:0] PW = 32'h430E_1F58;
  logic        clk_i = 1'b0, reset_i = 1'b1, hsel_i = 1'b0;
  logic        hwrite_i = 1'b0, slow = 1'b0, ap_q, rp_q;
  logic [1:0]  htrans_i = 2'h0;
  logic [31:0] haddr_i = '0, hwdata_i = '0, hrdata_o, rd, sc;
  logic [31:0] seed = 32'hA6B9_4DB5;
  logic [2:0]  kick = '0, mute = '0, new_n, rx_pin_i, rx_sel_o;
  logic [2:0]  pin_uart_mode_o, phase_missing_o;
  logic        hreadyout_o, hresp_o, uart_rx_o, cmd_valid_o;
  logic        cmd_ready_i, resp_done_i, act_pulse_o, react_pulse_o;
  logic [7:0]  cmd_byte_o, q_b[$];
  time         q_t[$], t0, tq;
  int n_mismatch = 0, n_compared = 0, n_act = 0, n_react = 0, act_hi = 0;

  always #5 clk_i = ~clk_i;

  afe_poll_scheduler #(.TICK_DIV(TD)) i_dut (
    .clk_i, .reset_i, .ce_i(1'b1), .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o),
    .hrdata_o, .hreadyout_o, .hresp_o, .new_params_line_n_i(new_n),
    .rx_pin_i, .rx_sel_o, .pin_uart_mode_o, .uart_rx_o, .cmd_valid_o,
    .cmd_byte_o, .cmd_ready_i, .resp_done_i, .phase_missing_o,
    .act_pulse_o, .react_pulse_o);

  afe_fe_model i_fe (
    .clk_i, .reset_i, .kick_i(kick), .mute_i(mute), .slow_i(slow),
    .cmd_valid_i(cmd_valid_o), .cmd_byte_i(cmd_byte_o),
    .new_params_n_o(new_n), .rx_pin_o(rx_pin_i),
    .cmd_ready_o(cmd_ready_i), .resp_done_o(resp_done_i));

  always @(posedge clk_i) begin
    if (cmd_valid_o === 1'b1 && cmd_ready_i === 1'b1) begin
      q_b.push_back(cmd_byte_o);
      q_t.push_back($time);
    end
    ap_q <= act_pulse_o;
    rp_q <= react_pulse_o;
    n_act += (act_pulse_o === 1'b1 && ap_q === 1'b0);
    n_react += (react_pulse_o === 1'b1 && rp_q === 1'b0);
    act_hi += (act_pulse_o === 1'b1);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i  <= {24'h00_0000, a};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask : bus

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(rd, e);
  endtask : rc

  task automatic want(input logic [7:0] b);
    repeat (2000) if (q_b.size() == 0) @(posedge clk_i);
    if (q_b.size() == 0) begin
      q_b.push_back('x);
      q_t.push_back(0);
    end
    t0 = q_t.pop_front();
    chk(32'(q_b.pop_front()), 32'(b));
  endtask : want

  task automatic pulse(input logic [2:0] p);
    @(posedge clk_i);
    kick <= p;
    repeat (4) @(posedge clk_i);
    kick <= 3'h0;
  endtask : pulse

  task automatic count_pulses(input int ticks);
    @(negedge clk_i);
    n_act = 0;
    n_react = 0;
    act_hi = 0;
    repeat (ticks * TD) @(negedge clk_i);
  endtask : count_pulses

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #(90_000 * 10);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    chk({20'h0_0000, rx_sel_o, pin_uart_mode_o, phase_missing_o,
         cmd_valid_o, uart_rx_o, act_pulse_o}, 32'h0000_0002);
    rc(OFS_PPK, {16'h0000, PPK_RESET});
    rc(OFS_PWIDTH, {16'h0000, PWIDTH_RESET});
    rc(8'h80, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      bus(1'b1, OFS_CUTOFF, seed);
      rc(OFS_CUTOFF, seed);
      bus(1'b1, OFS_PPK, seed);
      rc(OFS_PPK, {16'h0000, seed[15:0]});
    end
    $display("test registers done");
    bus(1'b1, OFS_PPK, {16'h0000, PPK_RESET});
    bus(1'b1, OFS_PWIDTH, 32'h0000_0001);
    bus(1'b1, OFS_CUTOFF, 32'h0000_0000);
    bus(1'b1, OFS_ACT, PW);
    bus(1'b1, OFS_REACT + 8'h08, -PW);
    repeat (5 * TD) @(posedge clk_i);
    count_pulses(40);
    chk(n_act, 20);
    chk(n_react, 20);
    chk(act_hi, 20 * TD);
    bus(1'b1, OFS_CUTOFF, PW);
    bus(1'b1, OFS_ACT + 8'h04, PW);
    repeat (3 * TD) @(posedge clk_i);
    count_pulses(40);
    chk(n_act + n_react, 0);
    $display("test energy done");
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    pulse(3'h4);
    repeat (15) @(posedge clk_i);
    pulse(3'h2);
    repeat (15) @(posedge clk_i);
    pulse(3'h1);
    bus(1'b0, OFS_STATUS, '0);
    chk({26'h0, rd[11:6]}, 32'h0000_0039);
    chk({29'h0, rd[2:0]}, 32'h0000_0000);
    bus(1'b0, OFS_STAMP + 8'h08, '0);
    sc = rd;
    bus(1'b0, OFS_STAMP + 8'h04, '0);
    tq = rd;
    chk(rd - sc, 32'h0000_0002);
    bus(1'b0, OFS_STAMP, '0);
    chk(rd - sc, 32'h0000_0004);
    chk(rd - 32'(tq), 32'h0000_0002);
    want(8'h61);
    want(8'h62);
    tq = t0;
    want(8'h63);
    chk(32'(t0 - tq), 78 * TK);
    repeat (20) @(posedge clk_i);
    chk({29'h0, phase_missing_o}, 32'h0000_0000);
    $display("test order done");
    bus(1'b1, OFS_CTRL, 32'h0000_0005);
    want(CMD_SYNC);
    for (int n = 1; n < 4; n++) begin
      bus(1'b1, OFS_CTRL, 32'h0000_0001 | (32'(n) << 4));
      want(8'h70 + 8'(n));
    end
    $display("test sync and calibration done");
    slow <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h0000_0003);
    pulse(3'h1);
    want(8'h61);
    chk({29'h0, pin_uart_mode_o}, 32'h0000_0001);
    repeat (60) @(posedge clk_i);
    chk({26'h0, rx_sel_o, pin_uart_mode_o}, 32'h0000_0000);
    $display("test two channel done");
    slow <= 1'b0;
    mute <= 3'h2;
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    pulse(3'h2);
    want(8'h62);
    repeat (990 * TD) @(posedge clk_i);
    chk({29'h0, rx_sel_o}, 32'h0000_0002);
    repeat (20 * TD) @(posedge clk_i);
    chk({29'h0, rx_sel_o}, 32'h0000_0000);
    $display("test command timeout done");
    repeat (45000) if (phase_missing_o[1] !== 1'b1) @(posedge clk_i);
    chk({31'h0, phase_missing_o[1]}, 32'h0000_0001);
    rc(OFS_ACT + 8'h04, 32'h0000_0000);
    $display("test readings timeout done");
    tally_and_finish();
  end
endmodule : tb
